/* File: mac_cfg.svh */
// named constants for the multiply-accumulate block: widths, register map,
// configuration field positions, mode codes and bus responses.
// assumes inclusion by bare name from the package and the design modules.
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH

`define OP_W 18
`define HALF_W 9
`define PROD_W 36
`define ACC_W 52
`define WIDE_W 72
`define OUT_W 144
`define ROWS 4
`define CTL_W 6

`define ADDR_W 4
`define REG_CFG 4'h0
`define REG_STATUS 4'h4
`define CFG_RST 32'h0000_0004
`define CFG_MASK 32'h0007_FFFF

`define CFG_MODE 1:0
`define CFG_WIDTH 3:2
`define CFG_IN_REG 4
`define CFG_PIPE_REG 5
`define CFG_OUT_REG 6
`define CFG_SHIFT_A 7
`define CFG_SHIFT_B 8
`define CFG_CTRL_DEPTH 10:9
`define CFG_GRP_IN 12:11
`define CFG_GRP_PIPE 14:13
`define CFG_GRP_OUT 16:15
`define CFG_GRP_CTRL 18:17

`define WID_9 2'h0
`define WID_18 2'h1
`define WID_36 2'h2

`define MODE_CODE_SIMPLE 2'h0
`define MODE_CODE_MAC 2'h1
`define MODE_CODE_ADD2 2'h2
`define MODE_CODE_ADD4 2'h3

`define DEPTH_NONE 2'h0
`define DEPTH_ONE 2'h1

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: mac_pkg.sv */
// types shared by the multiply-accumulate block modules.
// assumes mac_cfg.svh supplies the widths.
`include "mac_cfg.svh"
package mac_pkg;
	typedef enum logic [3:0] {
		MODE_SIMPLE = 4'h1,
		MODE_MAC = 4'h2,
		MODE_ADD2 = 4'h4,
		MODE_ADD4 = 4'h8
	} mode_e;
	typedef logic [`OP_W-1:0] operand_t;
	typedef logic [`PROD_W-1:0] product_t;
endpackage

/* File: mult_unit.sv */
// one multiplier sub-block: an 18x18 product, or two 9x9 products packed
// low half / high half. purely combinational.
// assumes the caller registers operands and product as configured.
`timescale 1ns/1ns
`include "mac_cfg.svh"
module mult_unit (
	input wire mac_pkg::operand_t a, // first operand
	input wire mac_pkg::operand_t b, // second operand
	input wire logic sign_a, // a is signed
	input wire logic sign_b, // b is signed
	input wire logic half_mode, // two 9x9 products instead of one
	output mac_pkg::product_t product // full precision result
);
	function automatic logic [`PROD_W-1:0] mul18(input logic [`OP_W-1:0] x,
		input logic [`OP_W-1:0] y, input logic sx, input logic sy);
		logic signed [`OP_W:0] xs;
		logic signed [`OP_W:0] ys;
		logic signed [2*`OP_W+1:0] p;
		xs = {sx & x[`OP_W-1], x};
		ys = {sy & y[`OP_W-1], y};
		p = xs * ys;
		return p[`PROD_W-1:0];
	endfunction

	function automatic logic [`OP_W-1:0] mul9(input logic [`HALF_W-1:0] x,
		input logic [`HALF_W-1:0] y, input logic sx, input logic sy);
		logic signed [`HALF_W:0] xs;
		logic signed [`HALF_W:0] ys;
		logic signed [2*`HALF_W+1:0] p;
		xs = {sx & x[`HALF_W-1], x};
		ys = {sy & y[`HALF_W-1], y};
		p = xs * ys;
		return p[`OP_W-1:0];
	endfunction

	always_comb begin
		if (half_mode) begin
			product = {mul9(a[`OP_W-1:`HALF_W], b[`OP_W-1:`HALF_W], sign_a, sign_b),
				mul9(a[`HALF_W-1:0], b[`HALF_W-1:0], sign_a, sign_b)};
		end else begin
			product = mul18(a, b, sign_a, sign_b);
		end
	end
endmodule

/* File: mac_block.sv */
// configurable multiply block: simple multiply, multiply-accumulate,
// two-product and four-product add, 36x36 multiply, input shift chains.
// assumes fabric operands and controls are on aclk; config over AXI4-Lite.
//
// Functional notes
// - simple mode passes each product out, four 18-bit or eight 9-bit
// - simple mode controls are unregistered or registered once
// - 36x36 product built from four 18x18 multipliers plus adder
// - no input shift chaining while in 36x36 mode
// - product register serves as the 36x36 pipeline stage
// - wide, accumulate, four-product controls delay zero, one or two
// - one or two accumulators fed by second and fourth multipliers
// - accumulator is 52 bits: 36-bit product plus 16 headroom
// - accumulator load and overflow exist only in accumulate mode
// - add/subtract lets accumulator subtract; overflow flags underflow
// - asserted load puts current product into accumulator
// - add/subtract select high adds, low subtracts
// - operand signed when its sign input is 1; product signed if any
// - two-product mode gives two 18-bit or four 9-bit pair sums
// - complex multiply: real via subtractor, imaginary via adder
// - four-product mode sums both first-stage adders
// - four-tap 18-bit FIR from data and coefficient shift chains
// - shift chains leave the block to feed adjacent blocks
// - eight rows of 18 outputs, nine leftward and nine rightward
// - each row brings one 18-bit operand and takes one output
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "mac_cfg.svh"
module mac_block (
	input wire logic aclk, // block clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [`ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [`ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [3:0] stage_enable, // four clock-enable groups
	input wire logic [3:0] stage_clear, // four clear groups
	input wire logic sign_a, // a operands signed
	input wire logic sign_b, // b operands signed
	input wire logic add_sub_select_first, // first adder: 1 add, 0 sub
	input wire logic add_sub_select_second, // second adder: 1 add, 0 sub
	input wire logic acc_load_first, // first accumulator load
	input wire logic acc_load_second, // second accumulator load
	input wire mac_pkg::operand_t operand_a_first, // row 1
	input wire mac_pkg::operand_t operand_b_first, // row 2
	input wire mac_pkg::operand_t operand_a_second, // row 3
	input wire mac_pkg::operand_t operand_b_second, // row 4
	input wire mac_pkg::operand_t operand_a_third, // row 5
	input wire mac_pkg::operand_t operand_b_third, // row 6
	input wire mac_pkg::operand_t operand_a_fourth, // row 7
	input wire mac_pkg::operand_t operand_b_last, // row 8
	input wire mac_pkg::operand_t shift_in_a, // a chain from block above
	input wire mac_pkg::operand_t shift_in_b, // b chain from block above
	output mac_pkg::operand_t shift_out_a, // a chain to block below
	output mac_pkg::operand_t shift_out_b, // b chain to block below
	output mac_pkg::operand_t product_out_first, // row 1 output
	output mac_pkg::operand_t product_out_second, // row 2 output
	output mac_pkg::operand_t product_out_third, // row 3 output
	output mac_pkg::operand_t product_out_fourth, // row 4 output
	output mac_pkg::operand_t product_out_fifth, // row 5 output
	output mac_pkg::operand_t product_out_sixth, // row 6 output
	output mac_pkg::operand_t product_out_seventh, // row 7 output
	output mac_pkg::operand_t product_out_last, // row 8 output
	output logic [`WIDE_W-1:0] dir_left_out, // low nine bits of each row
	output logic [`WIDE_W-1:0] dir_right_out, // high nine bits of each row
	output logic overflow_first, // first accumulator over/underflow
	output logic overflow_second // second accumulator over/underflow
);
	logic [31:0] cfg_q;
	logic [31:0] cfg_d;
	mac_pkg::mode_e mode;
	logic wid9;
	logic wid36;
	logic shift_a;
	logic shift_b;
	logic [1:0] depth;
	mac_pkg::operand_t op_a [`ROWS];
	mac_pkg::operand_t op_b [`ROWS];
	mac_pkg::operand_t a_q [`ROWS];
	mac_pkg::operand_t b_q [`ROWS];
	mac_pkg::operand_t ma [`ROWS];
	mac_pkg::operand_t mb [`ROWS];
	logic [`ROWS-1:0] msa;
	logic [`ROWS-1:0] msb;
	mac_pkg::product_t m [`ROWS];
	mac_pkg::product_t p_q [`ROWS];
	mac_pkg::product_t p [`ROWS];
	logic [`CTL_W-1:0] ctl;
	logic [`CTL_W-1:0] ctl1_q;
	logic [`CTL_W-1:0] ctl2_q;
	logic [`CTL_W-1:0] ctl_eff;
	logic c_sa, c_sb, c_as1, c_as2, c_ld1, c_ld2, psg;
	logic en_in, en_pipe, en_out, en_ctl;
	logic clr_in, clr_pipe, clr_out, clr_ctl;
	logic [`WIDE_W-1:0] e [`ROWS];
	logic [`WIDE_W-1:0] t0, t1, t2, t3;
	logic [`ACC_W:0] st0, st1;
	logic [`OUT_W-1:0] out_d;
	logic [`OUT_W-1:0] out_q;
	logic [1:0] ovf_d;
	logic [1:0] ovf_q;
	logic aw_full_q, w_full_q;
	logic [`ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	function automatic logic [`WIDE_W-1:0] ext36(input logic [`PROD_W-1:0] v,
		input logic sg);
		return {{(`WIDE_W-`PROD_W){sg & v[`PROD_W-1]}}, v};
	endfunction

	function automatic logic [`WIDE_W-1:0] ext18(input logic [`OP_W-1:0] v,
		input logic sg);
		return {{(`WIDE_W-`OP_W){sg & v[`OP_W-1]}}, v};
	endfunction

	function automatic logic [`WIDE_W-1:0] addsub(input logic [`WIDE_W-1:0] x,
		input logic [`WIDE_W-1:0] y, input logic add);
		return add ? x + y : x - y;
	endfunction

	// returns {overflow, next accumulator}; signed wraps use the sign carry
	function automatic logic [`ACC_W:0] acc_step(input logic [`ACC_W-1:0] acc,
		input logic [`WIDE_W-1:0] x, input logic add, input logic ld,
		input logic sg);
		logic [`ACC_W:0] a;
		logic [`ACC_W:0] y;
		logic [`ACC_W:0] s;
		a = {sg & acc[`ACC_W-1], acc};
		y = {sg & x[`ACC_W-1], x[`ACC_W-1:0]};
		s = add ? a + y : a - y;
		if (ld) begin
			return {1'b0, x[`ACC_W-1:0]};
		end
		return {sg ? s[`ACC_W] ^ s[`ACC_W-1] : s[`ACC_W], s[`ACC_W-1:0]};
	endfunction

	// configuration decode; mixing modes is impossible by construction
	always_comb begin
		case (cfg_q[`CFG_MODE])
			`MODE_CODE_MAC: mode = mac_pkg::MODE_MAC;
			`MODE_CODE_ADD2: mode = mac_pkg::MODE_ADD2;
			`MODE_CODE_ADD4: mode = mac_pkg::MODE_ADD4;
			default: mode = mac_pkg::MODE_SIMPLE;
		endcase
	end
	assign wid9 = cfg_q[`CFG_WIDTH] == `WID_9;
	assign wid36 = cfg_q[`CFG_WIDTH] == `WID_36;
	assign shift_a = cfg_q[`CFG_SHIFT_A] & cfg_q[`CFG_IN_REG] & !wid36;
	assign shift_b = cfg_q[`CFG_SHIFT_B] & cfg_q[`CFG_IN_REG] & !wid36;
	always_comb begin
		depth = cfg_q[`CFG_CTRL_DEPTH];
		if (mode == mac_pkg::MODE_SIMPLE && !wid36 && depth > `DEPTH_ONE) begin
			depth = `DEPTH_ONE;
		end
	end

	// stage groups: each stage picks one enable and one clear line
	assign en_in = stage_enable[cfg_q[`CFG_GRP_IN]];
	assign en_pipe = stage_enable[cfg_q[`CFG_GRP_PIPE]];
	assign en_out = stage_enable[cfg_q[`CFG_GRP_OUT]];
	assign en_ctl = stage_enable[cfg_q[`CFG_GRP_CTRL]];
	assign clr_in = stage_clear[cfg_q[`CFG_GRP_IN]];
	assign clr_pipe = stage_clear[cfg_q[`CFG_GRP_PIPE]];
	assign clr_out = stage_clear[cfg_q[`CFG_GRP_OUT]];
	assign clr_ctl = stage_clear[cfg_q[`CFG_GRP_CTRL]];

	// rows alternate a and b operands
	assign op_a[0] = operand_a_first;
	assign op_b[0] = operand_b_first;
	assign op_a[1] = operand_a_second;
	assign op_b[1] = operand_b_second;
	assign op_a[2] = operand_a_third;
	assign op_b[2] = operand_b_third;
	assign op_a[3] = operand_a_fourth;
	assign op_b[3] = operand_b_last;

	// input registers; with shifting, row i takes row i-1 for FIR taps
	always_ff @(posedge aclk) begin
		if (!aresetn || clr_in) begin
			for (int i = 0; i < `ROWS; i++) begin
				a_q[i] <= '0;
				b_q[i] <= '0;
			end
		end else if (en_in) begin
			a_q[0] <= shift_a ? shift_in_a : op_a[0];
			b_q[0] <= shift_b ? shift_in_b : op_b[0];
			for (int i = 1; i < `ROWS; i++) begin
				a_q[i] <= shift_a ? a_q[i-1] : op_a[i];
				b_q[i] <= shift_b ? b_q[i-1] : op_b[i];
			end
		end
	end
	assign shift_out_a = a_q[`ROWS-1];
	assign shift_out_b = b_q[`ROWS-1];

	// control delay line: zero, one or two registers
	assign ctl = {sign_a, sign_b, add_sub_select_first, add_sub_select_second,
		acc_load_first, acc_load_second};
	always_ff @(posedge aclk) begin
		if (!aresetn || clr_ctl) begin
			ctl1_q <= '0;
			ctl2_q <= '0;
		end else if (en_ctl) begin
			ctl1_q <= ctl;
			ctl2_q <= ctl1_q;
		end
	end
	always_comb begin
		case (depth)
			`DEPTH_NONE: ctl_eff = ctl;
			`DEPTH_ONE: ctl_eff = ctl1_q;
			default: ctl_eff = ctl2_q;
		endcase
	end
	assign {c_sa, c_sb, c_as1, c_as2, c_ld1, c_ld2} = ctl_eff;
	assign psg = c_sa | c_sb;

	// operand routing; 36x36 splits a and b into high and low halves
	always_comb begin
		for (int i = 0; i < `ROWS; i++) begin
			ma[i] = cfg_q[`CFG_IN_REG] ? a_q[i] : op_a[i];
			mb[i] = cfg_q[`CFG_IN_REG] ? b_q[i] : op_b[i];
			msa[i] = c_sa;
			msb[i] = c_sb;
		end
		if (wid36) begin
			ma[1] = ma[0];
			mb[2] = mb[0];
			mb[1] = cfg_q[`CFG_IN_REG] ? b_q[1] : op_b[1];
			ma[2] = cfg_q[`CFG_IN_REG] ? a_q[1] : op_a[1];
			ma[3] = ma[2];
			mb[3] = mb[1];
			msb[1] = 1'b0;
			msa[2] = 1'b0;
			msa[3] = 1'b0;
			msb[3] = 1'b0;
		end
	end

	for (genvar g = 0; g < `ROWS; g++) begin : gen_mult
		mult_unit u_mult (
			.a(ma[g]),
			.b(mb[g]),
			.sign_a(msa[g]),
			.sign_b(msb[g]),
			.half_mode(wid9),
			.product(m[g])
		);
	end

	// product register, which in 36x36 mode holds the four partials
	always_ff @(posedge aclk) begin
		if (!aresetn || clr_pipe) begin
			for (int i = 0; i < `ROWS; i++) begin
				p_q[i] <= '0;
			end
		end else if (en_pipe) begin
			for (int i = 0; i < `ROWS; i++) begin
				p_q[i] <= m[i];
			end
		end
	end
	always_comb begin
		for (int i = 0; i < `ROWS; i++) begin
			p[i] = cfg_q[`CFG_PIPE_REG] ? p_q[i] : m[i];
			e[i] = ext36(p[i], psg);
		end
	end

	// adder / output select
	always_comb begin
		out_d = '0;
		ovf_d = 2'h0;
		t0 = '0;
		t1 = '0;
		t2 = '0;
		t3 = '0;
		st0 = '0;
		st1 = '0;
		if (wid36) begin
			t0 = ext36(p[1], c_sa) + ext36(p[2], c_sb);
			t1 = (e[0] << `PROD_W) + (t0 << `OP_W) + {36'h0, p[3]};
			out_d[`WIDE_W-1:0] = t1;
		end else begin
			case (mode)
				mac_pkg::MODE_MAC: begin
					t0 = wid9 ? ext18(p[1][`OP_W-1:0], psg) : e[1];
					t1 = wid9 ? ext18(p[3][`OP_W-1:0], psg) : e[3];
					st0 = acc_step(out_q[`ACC_W-1:0], t0, c_as1, c_ld1, psg);
					st1 = acc_step(out_q[`WIDE_W+`ACC_W-1:`WIDE_W], t1, c_as2,
						c_ld2, psg);
					out_d[`ACC_W-1:0] = st0[`ACC_W-1:0];
					out_d[`WIDE_W+`ACC_W-1:`WIDE_W] = st1[`ACC_W-1:0];
					ovf_d = {st1[`ACC_W], st0[`ACC_W]};
				end
				mac_pkg::MODE_ADD2: begin
					if (wid9) begin
						for (int i = 0; i < 2; i++) begin
							t0 = addsub(ext18(p[0][i*`OP_W+:`OP_W], psg),
								ext18(p[1][i*`OP_W+:`OP_W], psg), c_as1);
							t1 = addsub(ext18(p[2][i*`OP_W+:`OP_W], psg),
								ext18(p[3][i*`OP_W+:`OP_W], psg), c_as2);
							out_d[i*`PROD_W+:`PROD_W] = t0[`PROD_W-1:0];
							out_d[`WIDE_W+i*`PROD_W+:`PROD_W] = t1[`PROD_W-1:0];
						end
					end else begin
						t0 = addsub(e[0], e[1], c_as1);
						t1 = addsub(e[2], e[3], c_as2);
						out_d[`WIDE_W-1:0] = t0;
						out_d[`OUT_W-1:`WIDE_W] = t1;
					end
				end
				mac_pkg::MODE_ADD4: begin
					if (wid9) begin
						t0 = addsub(ext18(p[0][`OP_W-1:0], psg),
							ext18(p[1][`OP_W-1:0], psg), c_as1);
						t1 = addsub(ext18(p[2][`OP_W-1:0], psg),
							ext18(p[3][`OP_W-1:0], psg), c_as2);
						t2 = addsub(ext18(p[0][`PROD_W-1:`OP_W], psg),
							ext18(p[1][`PROD_W-1:`OP_W], psg), c_as1);
						t3 = addsub(ext18(p[2][`PROD_W-1:`OP_W], psg),
							ext18(p[3][`PROD_W-1:`OP_W], psg), c_as2);
						out_d = {t2 + t3, t0 + t1};
					end else begin
						t0 = addsub(e[0], e[1], c_as1);
						t1 = addsub(e[2], e[3], c_as2);
						out_d[`WIDE_W-1:0] = t0 + t1;
					end
				end
				default: begin
					out_d = {p[3], p[2], p[1], p[0]};
				end
			endcase
		end
	end

	// output register; when not selected it reloads every cycle, so the
	// outputs always come from flops at one cycle of latency
	always_ff @(posedge aclk) begin
		if (!aresetn || (cfg_q[`CFG_OUT_REG] && clr_out)) begin
			out_q <= '0;
			ovf_q <= 2'h0;
		end else if (!cfg_q[`CFG_OUT_REG] || en_out) begin
			out_q <= out_d;
			ovf_q <= ovf_d;
		end
	end
	assign product_out_first = out_q[0*`OP_W+:`OP_W];
	assign product_out_second = out_q[1*`OP_W+:`OP_W];
	assign product_out_third = out_q[2*`OP_W+:`OP_W];
	assign product_out_fourth = out_q[3*`OP_W+:`OP_W];
	assign product_out_fifth = out_q[4*`OP_W+:`OP_W];
	assign product_out_sixth = out_q[5*`OP_W+:`OP_W];
	assign product_out_seventh = out_q[6*`OP_W+:`OP_W];
	assign product_out_last = out_q[7*`OP_W+:`OP_W];
	always_comb begin
		for (int i = 0; i < 2*`ROWS; i++) begin
			dir_left_out[i*`HALF_W+:`HALF_W] = out_q[i*`OP_W+:`HALF_W];
			dir_right_out[i*`HALF_W+:`HALF_W] =
				out_q[i*`OP_W+`HALF_W+:`HALF_W];
		end
	end
	assign overflow_first = ovf_q[0];
	assign overflow_second = ovf_q[1];

	// AXI4-Lite slave: address and data taken in either order
	assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
	assign s_axi_wready = !w_full_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	always_comb begin
		cfg_d = cfg_q;
		for (int i = 0; i < 4; i++) begin
			if (w_strb_q[i]) begin
				cfg_d[i*8+:8] = w_data_q[i*8+:8];
			end
		end
		cfg_d = cfg_d & `CFG_MASK;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			cfg_q <= `CFG_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (aw_full_q && w_full_q) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (aw_addr_q == `REG_CFG) begin
					cfg_q <= cfg_d;
				end else if (aw_addr_q != `REG_STATUS) begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			case (s_axi_araddr)
				`REG_CFG: s_axi_rdata <= cfg_q;
				`REG_STATUS: s_axi_rdata <= {25'h0, wid36, mode, ovf_q};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

/* File: fabric_model.sv */
// fabric side model: general logic registering the eight operand rows
// assumes the bench hands it the next row values, row 1 in the low bits
`timescale 1ns/1ns
module fabric_model (
	input wire logic aclk, // block clock
	input wire logic aresetn, // reset, active low
	input wire logic [143:0] ops_next, // next row values
	output logic [143:0] ops_q // rows as launched into the block
);
	// fabric flops launch just after the edge, like real logic rows
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ops_q <= 144'h0;
		end else begin
			ops_q <= ops_next;
		end
	end
endmodule

/* File: mac_block_monitor.sv */
// assertions on the multiply block ports: bus handshakes and row split
// assumes one clock, aclk, with aresetn synchronous and active low
`timescale 1ns/1ns
`include "mac_cfg.svh"
module mac_monitor (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire mac_pkg::operand_t product_out_first, // row 1
	input wire logic [`WIDE_W-1:0] dir_left_out, // left links
	input wire logic [`WIDE_W-1:0] dir_right_out // right links
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_reset_clean: assert property ($rose(aresetn) |->
		product_out_first == 18'h0 && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not clear after reset");
	a_wr_answer: assert property (wr_taken |=> ##[0:2] s_axi_bvalid)
		else $error("write not answered");
	a_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read not answered");
	a_wr_refuse: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid)
		else $error("write response not released");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid)
		else $error("read response not released");
	a_row_split: assert property (
		dir_left_out[8:0] == product_out_first[8:0]
		&& dir_right_out[8:0] == product_out_first[17:9])
		else $error("direct links disagree with row 1");
endmodule

bind mac_block mac_monitor mon_u (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .product_out_first, .dir_left_out, .dir_right_out);

/* File: tb_top.sv */
// self-checking bench: register bus, simple, wide, two and four product
// and accumulate modes; assumes fabric_model adds one edge on operands
`timescale 1ns/1ns
`include "mac_cfg.svh"
module tb_top;
	logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, sign_a = 1'h0, sign_b = 1'h0;
	logic acc_load_first = 1'h0, acc_load_second = 1'h0;
	logic add_sub_select_first = 1'h1, add_sub_select_second = 1'h1;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [3:0] s_axi_wstrb = 4'hF, stage_enable = 4'hF, stage_clear = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [143:0] ops_next = 144'h0, ops_q, outv;
	mac_pkg::operand_t shift_in_a = 18'h0, shift_in_b = 18'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, overflow_first, overflow_second;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [71:0] dir_left_out, dir_right_out;
	mac_pkg::operand_t operand_a_first, operand_b_first, operand_a_second;
	mac_pkg::operand_t operand_b_second, operand_a_third, operand_b_third;
	mac_pkg::operand_t operand_a_fourth, operand_b_last, shift_out_a;
	mac_pkg::operand_t shift_out_b, product_out_first, product_out_second;
	mac_pkg::operand_t product_out_third, product_out_fourth;
	mac_pkg::operand_t product_out_fifth, product_out_sixth;
	mac_pkg::operand_t product_out_seventh, product_out_last;
	int miscompares, cmp_count;
	assign {operand_b_last, operand_a_fourth, operand_b_third,
		operand_a_third, operand_b_second, operand_a_second,
		operand_b_first, operand_a_first} = ops_q;
	assign outv = {product_out_last, product_out_seventh, product_out_sixth,
		product_out_fifth, product_out_fourth, product_out_third,
		product_out_second, product_out_first};
	mac_block dut_u (.*);
	fabric_model fab_u (.aclk, .aresetn, .ops_next, .ops_q);
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic chk(input logic [71:0] got, input logic [71:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	// rready rides with the request; data taken at the edge rvalid is seen
	task automatic axi_rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic put(input logic [143:0] v);
		ops_next <= v;
		tick(4);
	endtask
	task automatic t_regs;
		axi_rd(`REG_CFG);
		chk(d, `CFG_RST);
		axi_rd(4'h8);
		chk(r, `RESP_SLVERR);
		axi_wr(4'hC, 32'h1);
		chk(r, `RESP_SLVERR);
	endtask
	task automatic t_simple;
		put({18'h100, 18'h12345, 72'h0, 18'h3FFFF, 18'h3FFFF});
		chk(outv[35:0], 36'hFFFF80001);
		chk(outv[143:108], 36'h1234500);
		sign_a <= 1'h1;
		tick(4);
		chk(outv[35:0], 36'hFFFFC0001);
		sign_a <= 1'h0;
		sign_b <= 1'h1;
		tick(4);
		chk(outv[35:0], 36'hFFFFC0001);
		sign_b <= 1'h0;
	endtask
	task automatic t_wide;
		axi_wr(`REG_CFG, 32'h8);
		put({72'h0, 18'h3, 18'h3FFFF, 18'h1, 18'h3FFFF});
		chk(outv[71:0], 72'hF_FFFF_FFFF * 72'h4_0003);
	endtask
	task automatic t_sums;
		add_sub_select_first <= 1'h0;
		axi_wr(`REG_CFG, 32'h6);
		put({18'h4, 18'h2, 18'h6, 18'h5, 18'hA, 18'hA, 18'h9, 18'h7});
		chk(outv[71:0], ~72'h24);
		chk(outv[143:72], 72'h26);
		chk(overflow_first, 1'h0);
		add_sub_select_first <= 1'h1;
		add_sub_select_second <= 1'h0;
		axi_wr(`REG_CFG, 32'h7);
		tick(4);
		chk(outv[71:0], 72'hB9);
		add_sub_select_second <= 1'h1;
	endtask
	task automatic t_mac;
		logic [51:0] v;
		logic seen;
		acc_load_first <= 1'h1;
		acc_load_second <= 1'h1;
		axi_wr(`REG_CFG, 32'h5);
		put({72'h0, 18'h5, 18'h3, 36'h0});
		chk(outv[51:0], 52'hF);
		axi_rd(`REG_STATUS);
		chk(d[5:2], 4'h2);
		acc_load_first <= 1'h0;
		acc_load_second <= 1'h0;
		tick(3);
		v = outv[51:0];
		tick(1);
		chk(outv[51:0] - v, 52'hF);
		add_sub_select_first <= 1'h0;
		tick(3);
		v = outv[51:0];
		tick(1);
		chk(v - outv[51:0], 52'hF);
		seen = 1'h0;
		repeat (40) begin
			tick(1);
			seen |= overflow_first;
		end
		chk(seen, 1'h1);
		chk(overflow_second, 1'h0);
	endtask
	task automatic t_chain;
		shift_in_a <= 18'h5;
		shift_in_b <= 18'h7;
		axi_wr(`REG_CFG, 32'h194);
		put(144'h0);
		tick(2);
		chk(shift_out_a, 18'h5);
		chk(outv[143:108], 36'h23);
		stage_clear <= 4'h1;
		tick(2);
		chk(shift_out_b, 18'h0);
		stage_clear <= 4'h0;
		axi_wr(`REG_CFG, 32'h198);
		put({72'h0, 18'h3, 18'h2, 18'h1, 18'h0});
		chk(outv[71:0], 72'h8_0006);
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		forever #20 aclk = ~aclk;
	end
	// far above the roughly 140 cycles the scenarios need
	initial begin
		repeat (3000) @(posedge aclk);
		miscompares++;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_regs;
		t_simple;
		t_wide;
		t_sums;
		t_mac;
		t_chain;
		report_and_stop;
	end
endmodule
